/* logic/mbsl_pkg.sv */
// Purpose: Shared constants and types for the slave request handler
// Assumes: 32-bit AHB-Lite register access, one 250 MHz clock
// Notes: Byte addresses below are decoded from the low address bits only
`default_nettype none

package mbsl_pkg;

    // Bus decode width and register byte addresses
    localparam int AW = 12;
    localparam logic [AW-1:0] A_INIT = 12'h000;
    localparam logic [AW-1:0] A_DISC_LIMIT = 12'h004;
    localparam logic [AW-1:0] A_ANA_LIMIT = 12'h008;
    localparam logic [AW-1:0] A_HOLD_LIMIT = 12'h00c;
    localparam logic [AW-1:0] A_HOLD_BASE = 12'h010;
    localparam logic [AW-1:0] A_WORK_BASE = 12'h014;
    localparam logic [AW-1:0] A_FUNC = 12'h018;
    localparam logic [AW-1:0] A_START = 12'h01c;
    localparam logic [AW-1:0] A_COUNT = 12'h020;
    localparam logic [AW-1:0] A_GO = 12'h024;
    localparam logic [AW-1:0] A_STATUS = 12'h028;
    localparam logic [AW-1:0] A_BUF_BASE = 12'h200;
    localparam logic [AW-1:0] A_BUF_END = 12'h3e0;
    localparam logic [AW-1:0] A_VMEM_BASE = 12'h800;
    localparam logic [AW-1:0] A_VMEM_END = 12'hc00;

    // Data areas
    localparam int BIT_POINTS = 128;
    localparam int OUT_BYTES = 16;
    localparam int ANA_WORDS = 32;
    localparam int XFER_WORDS = 120;
    localparam int VMEM_BYTES = 1024;
    localparam int VMEM_AW = 10;
    localparam logic [17:0] VMEM_SIZE = 18'h00400;
    localparam logic [17:0] WORK_BYTES = 18'h0030b;
    localparam logic [7:0] DISC_MAX = 8'h80;
    localparam logic [7:0] ANA_MAX = 8'h20;
    localparam logic [15:0] XFER_MAX = 16'h0078;

    // Function codes
    localparam logic [7:0] FC_RD_COILS = 8'h01;
    localparam logic [7:0] FC_RD_INPUTS = 8'h02;
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_ANA = 8'h04;
    localparam logic [7:0] FC_WR_COIL = 8'h05;
    localparam logic [7:0] FC_WR_HOLD = 8'h06;
    localparam logic [7:0] FC_WR_COILS = 8'h0f;
    localparam logic [7:0] FC_WR_HOLDS = 8'h10;

    // Result codes
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_RANGE = 8'h01;
    localparam logic [7:0] ERR_PARAM = 8'h04;
    localparam logic [7:0] ERR_OVERLAP = 8'h05;
    localparam logic [7:0] ERR_FUNC = 8'h08;
    localparam logic [7:0] ERR_ADDR = 8'h09;
    localparam logic [7:0] ERR_OFF = 8'h0a;

    // Status field positions
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ENABLED = 2;
    localparam int ST_SVC_LSB = 8;
    localparam int ST_INIT_LSB = 16;

    typedef enum logic [0:0] {PH_IDLE, PH_RUN} mbsl_phase_e;

endpackage

`default_nettype wire

/* logic/mbsl_slave.sv */
// Purpose: Slave request handler mapping one-based addresses onto data areas
// Assumes: Framing and CRC are handled upstream; software loads each request
// Notes: One element is served per clock; results land in the transfer buffer
//
// Our own choices: the address map and the AHB-Lite interface to the registers.
`default_nettype none
`timescale 1ns/100ps

module mbsl_slave (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    input wire logic [mbsl_pkg::BIT_POINTS-1:0] i_input_bits,
    input wire logic [mbsl_pkg::ANA_WORDS*16-1:0] i_analog_words,
    input wire logic [mbsl_pkg::OUT_BYTES-1:0] i_local_we,
    input wire logic [mbsl_pkg::BIT_POINTS-1:0] i_local_data,
    output logic [mbsl_pkg::BIT_POINTS-1:0] o_output_bits,
    output logic o_svc_done,
    output logic [7:0] o_svc_error
);

    typedef struct packed {
        mbsl_pkg::mbsl_phase_e phase;
        logic hreadyout;
        logic hresp;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [mbsl_pkg::AW-1:0] wr_addr;
        logic enabled;
        logic [7:0] disc_limit;
        logic [7:0] ana_limit;
        logic [15:0] hold_limit;
        logic [15:0] hold_base;
        logic [15:0] work_base;
        logic [7:0] func;
        logic [15:0] start;
        logic [15:0] count;
        logic [15:0] idx;
        logic [7:0] svc_err;
        logic [7:0] init_err;
        logic done;
        logic done_pulse;
        logic [mbsl_pkg::BIT_POINTS-1:0] out_bits;
        logic [mbsl_pkg::XFER_WORDS-1:0][15:0] xbuf;
        logic [mbsl_pkg::VMEM_BYTES-1:0][7:0] vmem;
    } mbsl_state_s;

    mbsl_state_s r_reg;
    mbsl_state_s r_next;
    logic [mbsl_pkg::BIT_POINTS-1:0] in_bits;

    // Input pins cross into the clock domain
    mbsl_sync #(.W(mbsl_pkg::BIT_POINTS)) u_in_sync (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_d(i_input_bits),
        .o_q(in_bits)
    );

    // Register read decode for the address phase
    function automatic logic [31:0] read_word(input logic [mbsl_pkg::AW-1:0] a);
        logic [31:0] v;
        logic [mbsl_pkg::AW-1:0] off;
        logic [mbsl_pkg::VMEM_AW-1:0] va;
        v = '0;
        off = a - mbsl_pkg::A_BUF_BASE;
        va = {a[mbsl_pkg::VMEM_AW-1:2], 2'b00};
        if (a >= mbsl_pkg::A_BUF_BASE && a < mbsl_pkg::A_BUF_END) begin
            v[15:0] = r_reg.xbuf[off[8:2]];
        end else if (a >= mbsl_pkg::A_VMEM_BASE && a < mbsl_pkg::A_VMEM_END) begin
            v = {r_reg.vmem[va], r_reg.vmem[va + 10'h001],
                 r_reg.vmem[va + 10'h002], r_reg.vmem[va + 10'h003]};
        end else begin
            case (a)
                mbsl_pkg::A_DISC_LIMIT: v[7:0] = r_reg.disc_limit;
                mbsl_pkg::A_ANA_LIMIT: v[7:0] = r_reg.ana_limit;
                mbsl_pkg::A_HOLD_LIMIT: v[15:0] = r_reg.hold_limit;
                mbsl_pkg::A_HOLD_BASE: v[15:0] = r_reg.hold_base;
                mbsl_pkg::A_WORK_BASE: v[15:0] = r_reg.work_base;
                mbsl_pkg::A_FUNC: v[7:0] = r_reg.func;
                mbsl_pkg::A_START: v[15:0] = r_reg.start;
                mbsl_pkg::A_COUNT: v[15:0] = r_reg.count;
                mbsl_pkg::A_STATUS: begin
                    v[mbsl_pkg::ST_BUSY] = (r_reg.phase == mbsl_pkg::PH_RUN);
                    v[mbsl_pkg::ST_DONE] = r_reg.done;
                    v[mbsl_pkg::ST_ENABLED] = r_reg.enabled;
                    v[mbsl_pkg::ST_SVC_LSB +: 8] = r_reg.svc_err;
                    v[mbsl_pkg::ST_INIT_LSB +: 8] = r_reg.init_err;
                end
                default: v = '0;
            endcase
        end
        return v;
    endfunction

    // Next-state logic: bus slave, request check, element engine
    always_comb begin
        logic [17:0] hb;
        logic [17:0] he;
        logic [17:0] wb;
        logic [17:0] we;
        logic [16:0] last;
        logic [15:0] lim;
        logic [15:0] cnt;
        logic [15:0] el;
        logic [mbsl_pkg::VMEM_AW-1:0] va;
        logic [mbsl_pkg::AW-1:0] off;
        logic fc_ok;
        logic idle;
        hb = '0;
        he = '0;
        wb = '0;
        we = '0;
        last = '0;
        lim = '0;
        cnt = '0;
        el = '0;
        va = '0;
        off = '0;
        fc_ok = 1'b0;
        r_next = r_reg;
        r_next.hreadyout = 1'b1;
        r_next.hresp = 1'b0;
        r_next.done_pulse = 1'b0;
        idle = (r_reg.phase == mbsl_pkg::PH_IDLE);

        // Data phase of a write; ignored while a request is running
        if (r_reg.wr_pend && idle) begin
            off = r_reg.wr_addr - mbsl_pkg::A_BUF_BASE;
            va = {r_reg.wr_addr[mbsl_pkg::VMEM_AW-1:2], 2'b00};
            if (r_reg.wr_addr >= mbsl_pkg::A_BUF_BASE &&
                r_reg.wr_addr < mbsl_pkg::A_BUF_END) begin
                r_next.xbuf[off[8:2]] = i_hwdata[15:0];
            end else if (r_reg.wr_addr >= mbsl_pkg::A_VMEM_BASE &&
                         r_reg.wr_addr < mbsl_pkg::A_VMEM_END) begin
                r_next.vmem[va] = i_hwdata[31:24];
                r_next.vmem[va + 10'h001] = i_hwdata[23:16];
                r_next.vmem[va + 10'h002] = i_hwdata[15:8];
                r_next.vmem[va + 10'h003] = i_hwdata[7:0];
            end else begin
                case (r_reg.wr_addr)
                    mbsl_pkg::A_DISC_LIMIT: r_next.disc_limit = i_hwdata[7:0];
                    mbsl_pkg::A_ANA_LIMIT: r_next.ana_limit = i_hwdata[7:0];
                    mbsl_pkg::A_HOLD_LIMIT: r_next.hold_limit = i_hwdata[15:0];
                    mbsl_pkg::A_HOLD_BASE: r_next.hold_base = i_hwdata[15:0];
                    mbsl_pkg::A_WORK_BASE: r_next.work_base = i_hwdata[15:0];
                    mbsl_pkg::A_FUNC: r_next.func = i_hwdata[7:0];
                    mbsl_pkg::A_START: r_next.start = i_hwdata[15:0];
                    mbsl_pkg::A_COUNT: r_next.count = i_hwdata[15:0];
                    mbsl_pkg::A_INIT: begin
                        // Parameter check; bit 0 asks to enable service
                        hb = {2'b00, r_reg.hold_base};
                        he = hb + {1'b0, r_reg.hold_limit, 1'b0};
                        wb = {2'b00, r_reg.work_base};
                        we = wb + mbsl_pkg::WORK_BYTES;
                        r_next.init_err = mbsl_pkg::ERR_NONE;
                        if (i_hwdata[0]) begin
                            if (r_reg.disc_limit > mbsl_pkg::DISC_MAX ||
                                r_reg.ana_limit > mbsl_pkg::ANA_MAX) begin
                                r_next.init_err = mbsl_pkg::ERR_PARAM;
                            end else if (he > mbsl_pkg::VMEM_SIZE ||
                                         we > mbsl_pkg::VMEM_SIZE) begin
                                r_next.init_err = mbsl_pkg::ERR_RANGE;
                            end else if (he != hb && hb < we && wb < he) begin
                                r_next.init_err = mbsl_pkg::ERR_OVERLAP;
                            end
                        end
                        r_next.enabled = i_hwdata[0] &&
                            (r_next.init_err == mbsl_pkg::ERR_NONE);
                    end
                    mbsl_pkg::A_GO: begin
                        // Request check before any element is touched
                        cnt = r_reg.count;
                        fc_ok = 1'b1;
                        case (r_reg.func)
                            mbsl_pkg::FC_RD_COILS, mbsl_pkg::FC_RD_INPUTS,
                            mbsl_pkg::FC_WR_COILS:
                                lim = {8'h00, r_reg.disc_limit};
                            mbsl_pkg::FC_WR_COIL: begin
                                lim = {8'h00, r_reg.disc_limit};
                                cnt = 16'h0001;
                            end
                            mbsl_pkg::FC_RD_ANA:
                                lim = {8'h00, r_reg.ana_limit};
                            mbsl_pkg::FC_RD_HOLD, mbsl_pkg::FC_WR_HOLDS:
                                lim = r_reg.hold_limit;
                            mbsl_pkg::FC_WR_HOLD: begin
                                lim = r_reg.hold_limit;
                                cnt = 16'h0001;
                            end
                            default: fc_ok = 1'b0;
                        endcase
                        last = {1'b0, r_reg.start} + {1'b0, cnt} - 17'h00001;
                        r_next.done = 1'b0;
                        if (!r_reg.enabled) begin
                            r_next.svc_err = mbsl_pkg::ERR_OFF;
                            r_next.done = 1'b1;
                        end else if (!fc_ok) begin
                            r_next.svc_err = mbsl_pkg::ERR_FUNC;
                            r_next.done = 1'b1;
                        end else if (r_reg.start == '0 || cnt == '0 ||
                                     last > {1'b0, lim} ||
                                     cnt > mbsl_pkg::XFER_MAX) begin
                            // Zero offset is illegal as offsets are one-based
                            r_next.svc_err = mbsl_pkg::ERR_ADDR;
                            r_next.done = 1'b1;
                        end else begin
                            r_next.count = cnt;
                            r_next.idx = '0;
                            r_next.phase = mbsl_pkg::PH_RUN;
                        end
                        r_next.done_pulse = r_next.done;
                    end
                    default: ;
                endcase
            end
        end

        // Address phase: reads answer from a flop in the data phase
        r_next.wr_pend = 1'b0;
        if (i_hsel && i_hready && i_htrans[1]) begin
            if (i_hwrite) begin
                r_next.wr_pend = 1'b1;
                r_next.wr_addr = i_haddr[mbsl_pkg::AW-1:0];
            end else begin
                r_next.hrdata = read_word(i_haddr[mbsl_pkg::AW-1:0]);
            end
        end

        // Element engine: one point or word per cycle
        case (r_reg.phase)
            mbsl_pkg::PH_IDLE: ;
            mbsl_pkg::PH_RUN: begin
                el = r_reg.start - 16'h0001 + r_reg.idx;
                va = mbsl_pkg::VMEM_AW'(r_reg.hold_base + {el[14:0], 1'b0});
                case (r_reg.func)
                    mbsl_pkg::FC_RD_COILS:
                        r_next.xbuf[r_reg.idx[6:4]][r_reg.idx[3:0]] =
                            r_reg.out_bits[el[6:0]];
                    mbsl_pkg::FC_RD_INPUTS:
                        r_next.xbuf[r_reg.idx[6:4]][r_reg.idx[3:0]] =
                            in_bits[el[6:0]];
                    mbsl_pkg::FC_RD_ANA:
                        r_next.xbuf[r_reg.idx[6:0]] =
                            i_analog_words[el[4:0]*16 +: 16];
                    mbsl_pkg::FC_RD_HOLD:
                        r_next.xbuf[r_reg.idx[6:0]] =
                            {r_reg.vmem[va], r_reg.vmem[va + 10'h001]};
                    mbsl_pkg::FC_WR_COIL:
                        r_next.out_bits[el[6:0]] =
                            (r_reg.xbuf[0] != '0);
                    mbsl_pkg::FC_WR_COILS:
                        r_next.out_bits[el[6:0]] =
                            r_reg.xbuf[r_reg.idx[6:4]][r_reg.idx[3:0]];
                    mbsl_pkg::FC_WR_HOLD, mbsl_pkg::FC_WR_HOLDS: begin
                        r_next.vmem[va] =
                            r_reg.xbuf[r_reg.idx[6:0]][15:8];
                        r_next.vmem[va + 10'h001] =
                            r_reg.xbuf[r_reg.idx[6:0]][7:0];
                    end
                    default: ;
                endcase
                r_next.idx = r_reg.idx + 16'h0001;
                if (r_reg.idx == r_reg.count - 16'h0001) begin
                    r_next.phase = mbsl_pkg::PH_IDLE;
                    r_next.svc_err = mbsl_pkg::ERR_NONE;
                    r_next.done = 1'b1;
                    r_next.done_pulse = 1'b1;
                end
            end
            default: r_next.phase = mbsl_pkg::PH_IDLE;
        endcase

        // Local writes come last so they overwrite engine writes in the same cycle
        for (int b = 0; b < mbsl_pkg::OUT_BYTES; b++) begin
            if (i_local_we[b]) begin
                r_next.out_bits[b*8 +: 8] = i_local_data[b*8 +: 8];
            end
        end
    end

    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            r_reg <= '0;
            r_reg.hreadyout <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_hreadyout = r_reg.hreadyout;
    assign o_hrdata = r_reg.hrdata;
    assign o_hresp = r_reg.hresp;
    assign o_output_bits = r_reg.out_bits;
    assign o_svc_done = r_reg.done_pulse;
    assign o_svc_error = r_reg.svc_err;

endmodule // mbsl_slave

`default_nettype wire

/* logic/mbsl_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Inputs are asynchronous to i_clock
// Notes: A bit only changes once the second and third stages agree
`default_nettype none
`timescale 1ns/100ps

module mbsl_sync #(
    parameter int W = 8
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } mbsl_sync_s;

    mbsl_sync_s r_reg;
    mbsl_sync_s r_next;

    // Shift chain; the first stage feeds only the second
    always_comb begin
        r_next = r_reg;
        r_next.s1 = i_d;
        r_next.s2 = r_reg.s1;
        r_next.s3 = r_reg.s2;
        for (int b = 0; b < W; b++) begin
            if (r_reg.s2[b] == r_reg.s3[b]) begin
                r_next.q[b] = r_reg.s3[b];
            end
        end
    end

    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_q = r_reg.q;

endmodule // mbsl_sync

`default_nettype wire

/* testbench/mbsl_field.sv */
// Purpose: Field-side model feeding input pins and analog words
// Assumes: Values are static so pin latency does not matter
// Notes: Patterns chosen so neighbouring pin bytes and analog words differ
`timescale 1ns/100ps
`default_nettype none
module mbsl_field (
    output logic [mbsl_pkg::BIT_POINTS-1:0] o_input_bits,
    output logic [mbsl_pkg::ANA_WORDS*16-1:0] o_analog_words
);
    // Fixed pin image; analog word k reads a000 plus k
    always_comb begin
        o_input_bits = {8{16'hc35a}};
        for (int k = 0; k < mbsl_pkg::ANA_WORDS; k++) begin
            o_analog_words[16*k +: 16] = 16'ha000 + 16'(k);
        end
    end
endmodule // mbsl_field
`default_nettype wire

/* testbench/mbsl_slave_chk.sv */
// Purpose: Port checker for the slave request handler
// Assumes: One clock, synchronous reset
// Notes: Bound onto the handler below
`timescale 1ns/100ps
`default_nettype none
module mbsl_slave_chk (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic i_hready,
    input wire logic o_hreadyout,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hresp,
    input wire logic [15:0] i_local_we,
    input wire logic [127:0] i_local_data,
    input wire logic [127:0] o_output_bits,
    input wire logic o_svc_done,
    input wire logic [7:0] o_svc_error
);
    default clocking @(posedge i_clock);
    endclocking
    default disable iff (i_rst);
    // Bus answers, engine completion and output image
    a_ready_high: assert property (o_hreadyout && !o_hresp)
        else $error("bus slave stalled or errored");
    a_unmapped_zero: assert property (i_hsel && i_hready && i_htrans[1]
        && !i_hwrite && i_haddr[11:0] == 12'h100 |=> o_hrdata == 0)
        else $error("unmapped read not zero");
    a_local_wins: assert property (i_local_we[1] |=>
        o_output_bits[15:8] == $past(i_local_data[15:8]))
        else $error("local output write lost");
    a_done_single: assert property (o_svc_done |=> !o_svc_done)
        else $error("done longer than one cycle");
    a_err_at_done: assert property ($changed(o_svc_error) |-> o_svc_done)
        else $error("result changed without done");
    a_err_codes: assert property (o_svc_done |-> o_svc_error inside
        {8'h00, 8'h08, 8'h09, 8'h0a})
        else $error("unexpected result code");
    a_go_answers: assert property (i_hsel && i_hready && i_htrans[1]
        && i_hwrite && i_haddr[11:0] == 12'h024 |-> ##[2:125] o_svc_done)
        else $error("request never completed");
    a_rst_clean: assert property ($fell(i_rst) |->
        o_output_bits == 0 && o_svc_error == 0)
        else $error("outputs not cleared by reset");
endmodule // mbsl_slave_chk
bind mbsl_slave mbsl_slave_chk u_chk (.i_clock, .i_rst, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hready, .o_hreadyout, .o_hrdata, .o_hresp,
    .i_local_we, .i_local_data, .o_output_bits, .o_svc_done, .o_svc_error);
`default_nettype wire

/* testbench/mbsl_slave_tb.sv */
// Purpose: Self-checking bench for the slave request handler
// Assumes: Zero-wait slave, one 250 MHz clock
// Notes: Limits 16 discrete, 4 analog, 8 holding from 0x310
`timescale 1ns/100ps
`default_nettype none
module mbsl_slave_tb;
    typedef struct packed {
        logic [7:0] fc;
        logic [15:0] st;
        logic [15:0] cnt;
        logic [7:0] er;
    } mbsl_row_s;
    logic i_clock = 0, i_rst = 1, i_hsel = 0, i_hwrite = 0;
    logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, rv;
    logic [1:0] i_htrans = 0;
    logic [2:0] i_hsize = 3'h2;
    logic [15:0] i_local_we = 0;
    logic [127:0] i_local_data = 0, o_output_bits, i_input_bits;
    logic [511:0] i_analog_words;
    logic o_hreadyout, o_hresp, o_svc_done;
    logic [7:0] o_svc_error;
    int fails = 0, checked = 0;
    mbsl_row_s rows [12] = '{
        '{8'h07, 16'h1, 16'h1, 8'h08},
        '{8'h01, 16'h0, 16'h1, 8'h09},
        '{8'h01, 16'h10, 16'h1, 8'h00},
        '{8'h02, 16'h11, 16'h1, 8'h09},
        '{8'h04, 16'h4, 16'h1, 8'h00},
        '{8'h04, 16'h5, 16'h1, 8'h09},
        '{8'h03, 16'h1, 16'h8, 8'h00},
        '{8'h10, 16'h1, 16'h9, 8'h09},
        '{8'h0f, 16'h9, 16'h8, 8'h00},
        '{8'h05, 16'h1, 16'h1, 8'h00},
        '{8'h06, 16'h8, 16'h1, 8'h00},
        '{8'h10, 16'h1, 16'h8, 8'h00}};
    // Clock and units
    always #2 i_clock = ~i_clock;
    mbsl_slave u_dut (.i_clock, .i_rst, .i_hsel, .i_haddr, .i_htrans,
        .i_hwrite, .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout,
        .o_hrdata, .o_hresp, .i_input_bits, .i_analog_words, .i_local_we,
        .i_local_data, .o_output_bits, .o_svc_done, .o_svc_error);
    mbsl_field u_field (.o_input_bits(i_input_bits),
        .o_analog_words(i_analog_words));
    task automatic finish_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Next edge where hready is sampled high, bounded
    task automatic rdy;
        int n;
        n = 0;
        @(posedge i_clock);
        while (o_hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fails++;
                finish_test();
            end
            @(posedge i_clock);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_hsel <= 1;
        i_htrans <= 2'h2;
        i_haddr <= {20'h0, a};
        i_hwrite <= 1;
        rdy();
        i_htrans <= 2'h0;
        i_hwdata <= d;
        rdy();
    endtask
    task automatic rd(input logic [11:0] a);
        i_hsel <= 1;
        i_htrans <= 2'h2;
        i_haddr <= {20'h0, a};
        i_hwrite <= 0;
        rdy();
        i_htrans <= 2'h0;
        rdy();
        rv = o_hrdata;
    endtask
    // Load a request, start it and check the result code
    task automatic cmd(input logic [7:0] fc, input logic [15:0] st, cnt,
        input logic [7:0] ex);
        int n;
        n = 0;
        wr(12'h018, {24'h0, fc});
        wr(12'h01c, {16'h0, st});
        wr(12'h020, {16'h0, cnt});
        wr(12'h024, 32'h1);
        while (o_svc_done !== 1'b1) begin
            n++;
            if (n > 300) begin
                fails++;
                finish_test();
            end
            @(posedge i_clock);
        end
        chk({24'h0, o_svc_error}, {24'h0, ex});
    endtask
    // Hang guard
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 0;
        @(posedge i_clock);
        rd(12'h028);
        chk(rv | o_output_bits[31:0], 32'h0);
        rd(12'h100);
        chk(rv, 32'h0);
        // Service refused before init; oversized discrete limit rejected
        cmd(8'h01, 16'h1, 16'h1, 8'h0a);
        wr(12'h004, 32'h81);
        wr(12'h000, 32'h1);
        rd(12'h028);
        chk(rv[23:16], 8'h04);
        wr(12'h004, 32'h10);
        wr(12'h008, 32'h4);
        wr(12'h00c, 32'h8);
        wr(12'h014, 32'h0);
        wr(12'h010, 32'h100);
        wr(12'h000, 32'h1);
        rd(12'h028);
        chk(rv[23:16], 8'h05);
        // Holding area running past the end of variable memory
        wr(12'h010, 32'h3fc);
        wr(12'h000, 32'h1);
        rd(12'h028);
        chk(rv[23:16], 8'h01);
        wr(12'h010, 32'h310);
        wr(12'h000, 32'h1);
        rd(12'h028);
        chk(rv[23:16], 8'h00);
        foreach (rows[i]) cmd(rows[i].fc, rows[i].st, rows[i].cnt, rows[i].er);
        // Holding entry 2 lands at base plus 2, high byte first
        wr(12'h200, 32'hbeef);
        cmd(8'h06, 16'h2, 16'h1, 8'h00);
        rd(12'hb10);
        chk(rv[15:0], 16'hbeef);
        wr(12'h200, 32'h0);
        cmd(8'h03, 16'h2, 16'h1, 8'h00);
        rd(12'h200);
        chk(rv, 32'hbeef);
        cmd(8'h04, 16'h2, 16'h1, 8'h00);
        rd(12'h200);
        chk(rv, 32'ha001);
        cmd(8'h02, 16'h1, 16'h10, 8'h00);
        rd(12'h200);
        chk(rv, 32'hc35a);
        // Byte-aligned block of eight coils, then read back
        wr(12'h200, 32'h5a);
        cmd(8'h0f, 16'h1, 16'h8, 8'h00);
        chk(o_output_bits[7:0], 8'h5a);
        wr(12'h200, 32'h0);
        cmd(8'h01, 16'h1, 16'h8, 8'h00);
        rd(12'h200);
        chk(rv, 32'h5a);
        // Single coil set, then a local write overrides it
        wr(12'h200, 32'h1);
        cmd(8'h05, 16'h10, 16'h1, 8'h00);
        chk(o_output_bits[15], 1'b1);
        i_local_we <= 16'h2;
        @(posedge i_clock);
        i_local_we <= 16'h0;
        @(posedge i_clock);
        chk(o_output_bits[15], 1'b0);
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h1);
        cmd(8'h01, 16'h1, 16'h1, 8'h09);
        finish_test();
    end
endmodule // mbsl_slave_tb
`default_nettype wire
